// >>> design/bus_phy_pkg.sv
package bus_phy_pkg;

  localparam int NUM_CH = 2;

  // Clock and update timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int FAST_UPDATE_NS  = 1400000;
  localparam int SLOW_UPDATE_NS  = 180224000;
  localparam int FAST_UPDATE_CYC = FAST_UPDATE_NS / CLK_PERIOD_NS;
  localparam int SLOW_UPDATE_CYC = SLOW_UPDATE_NS / CLK_PERIOD_NS;
  localparam int FAST_UPDATES    = 64;

  // Bit building: oscillator cycles per bus bit, last phase index
  localparam int         OSC_PER_BIT = 3;
  localparam logic [1:0] PH_LAST     = 2'(OSC_PER_BIT - 1);

  // One oscillator period at offset 0 is 275 cycles; period*(512+off)
  // stays at this product when the centre is right.
  localparam int          PLL_K       = 275 * 512;
  localparam int          MEAS_OSC    = 32;
  localparam logic [25:0] PLL_TARGET  = 26'(MEAS_OSC * PLL_K);
  localparam logic [9:0]  OFFSET_BASE = 10'h200;
  localparam logic [9:0]  CENTRE_RST  = 10'h113;
  localparam logic [9:0]  CENTRE_MIN  = 10'h040;
  localparam logic [9:0]  CENTRE_MAX  = 10'h3ff;

  // Spread code
  localparam logic [5:0]  SPREAD_MID  = 6'h20;
  localparam logic [14:0] PRBS_SEED   = 15'h0001;

  // Register map, per channel block of 16 bytes
  localparam logic [11:0] REG_SS_CTRL = 12'h000;
  localparam logic [11:0] REG_OFFSET  = 12'h004;
  localparam logic [11:0] REG_STATUS  = 12'h008;
  localparam logic [11:0] CH_STRIDE   = 12'h010;

  localparam int SSC_EN_BIT     = 0;
  localparam int SSC_DEV_LO_BIT = 1;
  localparam int SSC_DEV_HI_BIT = 2;
  localparam int SSC_LEN_LSB    = 3;
  localparam int STS_CENTRE_LSB = 0;
  localparam int STS_CODE_LSB   = 10;
  localparam int STS_FAST_BIT   = 16;
  localparam int STS_FRAME_BIT  = 17;

  localparam logic [4:0] SSC_RST    = 5'h00;
  localparam logic [7:0] OFFSET_RST = 8'h00;

  // Gray along idle -> high -> low
  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_HIGH = 2'b01,
    DRV_LOW  = 2'b11,
    DRV_HIZ  = 2'b10
  } drive_state_t;

endpackage

// >>> design/prbs_gen.sv
`timescale 1ns/100ps
module prbs_gen
  import bus_phy_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       step,
  input  wire logic [1:0] len_sel,
  output logic      [5:0] code
);

  logic [14:0] lfsr_q;
  logic [14:0] mask;
  logic        fb;

  always_comb
  begin
    case (len_sel)
      2'h0:
      begin
        fb   = lfsr_q[5] ^ lfsr_q[4];
        mask = 15'h003f;
      end
      2'h1:
      begin
        fb   = lfsr_q[6] ^ lfsr_q[5];
        mask = 15'h007f;
      end
      2'h2:
      begin
        fb   = lfsr_q[10] ^ lfsr_q[8];
        mask = 15'h07ff;
      end
      default:
      begin
        fb   = lfsr_q[14] ^ lfsr_q[13];
        mask = 15'h7fff;
      end
    endcase
  end

  // A length change may leave the active bits all zero; reseed then
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      lfsr_q <= PRBS_SEED;
    else if ((lfsr_q & mask) == 15'h0000)
      lfsr_q <= PRBS_SEED;
    else if (step)
      lfsr_q <= {lfsr_q[13:0], fb};
  end

  assign code = lfsr_q[5:0];

endmodule // prbs_gen

// >>> design/bus_phy_spread.sv
`timescale 1ns/100ps
// Behaviour
// - Map frame and level to idle, hi-Z, high, low
// - Pass return data only while framing, no thermal
// - Thermal limit forces hi-Z and zero response
// - Spreading per channel, only when enable bit set
// - Sixty-four evenly spaced bit durations at full deviation
// - Each bus bit is three oscillator cycles
// - Loop compares clock reference with oscillator period
// - Fast phase after reset and offset write
// - Fast phase is 64 updates of 1.4 ms
// - Then slow updates every 180.224 ms
// - Centre updates far slower than spread steps
// - Maximal PRBS of length 6, 7, 11, 15
// - Paired bit periods keep even frames constant
// - Two deviation bits pick off, 1/4, 1/2 or full deviation
// - Spread word changes at bit start; frame fall or spread off resets it to mid
// - Frame starts on frame fall, bits on level fall
// - Level low one third for 1, two for 0
module bus_phy_spread
  import bus_phy_pkg::*;
#(
  parameter int FAST_CYC = FAST_UPDATE_CYC,
  parameter int SLOW_CYC = SLOW_UPDATE_CYC
)(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [NUM_CH-1:0]        frame_ctrl_n,
  input  wire logic [NUM_CH-1:0]        tx_bit,
  output logic      [NUM_CH-1:0]        tx_bit_take,
  output logic      [NUM_CH-1:0]        bus_level_ctrl,
  input  wire logic [NUM_CH-1:0]        thermal_limit,
  input  wire logic [NUM_CH-1:0]        bus_return_raw,
  output logic      [NUM_CH-1:0]        slave_response_bit,
  output drive_state_t [NUM_CH-1:0]     bus_drive_state,
  output logic      [NUM_CH-1:0]        idle_drv_en,
  output logic      [NUM_CH-1:0]        signal_drv_en,
  output logic      [NUM_CH-1:0][5:0]   spread_dac_code,
  output logic      [NUM_CH-1:0][9:0]   centre_dac_code
);

  logic [4:0]  spread_control_reg [NUM_CH];
  logic [7:0]  offset_q [NUM_CH];
  logic [31:0] status_w [NUM_CH];
  logic [NUM_CH-1:0] offset_wr;
  logic [31:0] rd_data;
  logic        hit;
  logic        wr_ok;
  logic [31:0] prdata_q;

  // Register decode; status words are read-only
  always_comb
  begin
    hit       = 1'b0;
    rd_data   = 32'h0000_0000;
    offset_wr = '0;
    wr_ok     = psel && penable && pwrite;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (paddr == REG_SS_CTRL + 12'(c) * CH_STRIDE)
      begin
        hit     = 1'b1;
        rd_data = {27'h0, spread_control_reg[c]};
      end
      else if (paddr == REG_OFFSET + 12'(c) * CH_STRIDE)
      begin
        hit          = 1'b1;
        rd_data      = {24'h0, offset_q[c]};
        offset_wr[c] = wr_ok;
      end
      else if (paddr == REG_STATUS + 12'(c) * CH_STRIDE)
      begin
        hit     = 1'b1;
        rd_data = status_w[c];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        spread_control_reg[c] <= SSC_RST;
        offset_q[c]           <= OFFSET_RST;
      end
    end
    else if (wr_ok)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (paddr == REG_SS_CTRL + 12'(c) * CH_STRIDE)
          spread_control_reg[c] <= pwdata[4:0];
        if (offset_wr[c])
          offset_q[c] <= pwdata[7:0];
      end
    end
  end

  // Read data is latched in the setup cycle so it is a flop output
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_q <= rd_data;
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    logic        frame_d1_q;
    logic        frame_fall;
    logic [10:0] osc_cnt_q;
    logic        osc_tick;
    logic [1:0]  ph_q;
    logic        lead_q;
    logic        data_q;
    logic        level_q;
    logic        level_d;
    logic        bit_start;
    logic        spread_on;
    logic [1:0]  dev;
    logic [5:0]  code_q;
    logic        pair_q;
    logic [5:0]  prbs_code;
    logic signed [7:0]  step_s;
    logic signed [11:0] period_s;
    logic [10:0] period;
    logic [9:0]  centre_q;
    logic [15:0] meas_cyc_q;
    logic [4:0]  meas_osc_q;
    logic [15:0] meas_q;
    logic        meas_ok_q;
    logic [25:0] prod;
    logic [24:0] timer_q;
    logic [6:0]  fast_left_q;
    logic        upd_tick;
    drive_state_t drv_d;
    drive_state_t drv_q;
    logic        trans_q;
    logic        trans_d;
    logic        idle_q;
    logic        sig_q;
    logic        resp_q;

    assign frame_fall = frame_d1_q && !frame_ctrl_n[g];
    assign dev = {spread_control_reg[g][SSC_DEV_HI_BIT],
                  spread_control_reg[g][SSC_DEV_LO_BIT]};
    assign spread_on = spread_control_reg[g][SSC_EN_BIT]
                       && (dev != 2'h0);

    // Deviation span scales 1/4, 1/2, full with the two deviation bits
    always_comb
    begin
      step_s   = 8'(signed'({2'b00, code_q}) - 8'sd32);
      step_s   = step_s >>> (2'd3 - dev);
      period_s = signed'({2'b00, centre_q}) + 12'(step_s);
      if (period_s < 12'sd2)
        period = 11'h002;
      else
        period = period_s[10:0];
    end

    // Compare with >= so a centre step mid-period cannot skip the tick
    assign osc_tick  = (osc_cnt_q >= period - 11'h001);
    // No data bit starts on the edge that detects the frame fall
    assign bit_start = osc_tick && (ph_q == PH_LAST)
                       && !frame_ctrl_n[g] && !frame_d1_q;
    assign tx_bit_take[g] = bit_start;

    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
        frame_d1_q <= 1'b1;
      else
        frame_d1_q <= frame_ctrl_n[g];
    end

    // Oscillator model, realigned to the frame start
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
        osc_cnt_q <= 11'h000;
      else if (frame_fall || osc_tick)
        osc_cnt_q <= 11'h000;
      else
        osc_cnt_q <= osc_cnt_q + 11'h001;
    end

    // First bit after frame fall is a lead bit held high
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        ph_q   <= 2'h0;
        lead_q <= 1'b0;
        data_q <= 1'b1;
      end
      else if (frame_fall)
      begin
        ph_q   <= 2'h0;
        lead_q <= 1'b1;
      end
      else if (osc_tick)
      begin
        ph_q <= (ph_q == PH_LAST) ? 2'h0 : ph_q + 2'h1;
        if (bit_start)
        begin
          lead_q <= 1'b0;
          data_q <= tx_bit[g];
        end
      end
    end

    always_comb
    begin
      if (frame_ctrl_n[g] || lead_q || frame_fall)
        level_d = 1'b1;
      else if (ph_q == 2'h0)
        level_d = 1'b0;
      else if (ph_q == 2'h1)
        level_d = data_q;
      else
        level_d = 1'b1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
        level_q <= 1'b1;
      else
        level_q <= level_d;
    end

    prbs_gen u_prbs (
      .sys_clk (sys_clk),
      .rst     (rst),
      .step    (bit_start && spread_on && !pair_q),
      .len_sel (spread_control_reg[g][SSC_LEN_LSB +: 2]),
      .code    (prbs_code)
    );

    // Odd bits mirror the previous code so each pair sums the same
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        code_q <= SPREAD_MID;
        pair_q <= 1'b0;
      end
      else if (!spread_on)
      begin
        code_q <= SPREAD_MID;
        pair_q <= 1'b0;
      end
      // Lead bit runs at mid so only data bits pair up
      else if (frame_fall)
      begin
        code_q <= SPREAD_MID;
        pair_q <= 1'b0;
      end
      else if (bit_start)
      begin
        code_q <= pair_q ? ~code_q : prbs_code;
        pair_q <= !pair_q;
      end
    end

    // Period measurement over 32 oscillator cycles
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        meas_cyc_q <= 16'h0000;
        meas_osc_q <= 5'h00;
        meas_q     <= 16'h0000;
        meas_ok_q  <= 1'b0;
      end
      else if (osc_tick && meas_osc_q == 5'(MEAS_OSC - 1))
      begin
        meas_q     <= meas_cyc_q + 16'h0001;
        meas_cyc_q <= 16'h0000;
        meas_osc_q <= 5'h00;
        meas_ok_q  <= 1'b1;
      end
      else
      begin
        meas_cyc_q <= meas_cyc_q + 16'h0001;
        if (osc_tick)
          meas_osc_q <= meas_osc_q + 5'h01;
      end
    end

    assign prod = 26'(meas_q) * 26'(OFFSET_BASE + 10'(offset_q[g]));
    assign upd_tick = (fast_left_q != 7'h00)
                      ? (timer_q == 25'(FAST_CYC - 1))
                      : (timer_q == 25'(SLOW_CYC - 1));

    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        timer_q     <= 25'h0000000;
        fast_left_q <= 7'(FAST_UPDATES);
      end
      else if (offset_wr[g])
      begin
        timer_q     <= 25'h0000000;
        fast_left_q <= 7'(FAST_UPDATES);
      end
      else if (upd_tick)
      begin
        timer_q <= 25'h0000000;
        if (fast_left_q != 7'h00)
          fast_left_q <= fast_left_q - 7'h01;
      end
      else
        timer_q <= timer_q + 25'h0000001;
    end

    // One step per update; the update spacing dwarfs a bit time
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
        centre_q <= CENTRE_RST;
      else if (upd_tick && meas_ok_q)
      begin
        if (prod > PLL_TARGET && centre_q > CENTRE_MIN)
          centre_q <= centre_q - 10'h001;
        else if (prod < PLL_TARGET && centre_q < CENTRE_MAX)
          centre_q <= centre_q + 10'h001;
      end
    end

    always_comb
    begin
      if (thermal_limit[g])
        drv_d = DRV_HIZ;
      else if (frame_ctrl_n[g])
        drv_d = level_q ? DRV_IDLE : DRV_HIZ;
      else
        drv_d = level_q ? DRV_HIGH : DRV_LOW;
      if (drv_d == DRV_IDLE)
        trans_d = 1'b1;
      else if (drv_d == DRV_HIGH)
        trans_d = trans_q;
      else
        trans_d = 1'b0;
    end

    // Idle driver keeps the bus through the idle/high handoff
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        drv_q   <= DRV_HIZ;
        trans_q <= 1'b0;
        idle_q  <= 1'b0;
        sig_q   <= 1'b0;
        resp_q  <= 1'b0;
      end
      else
      begin
        drv_q   <= drv_d;
        trans_q <= trans_d;
        idle_q  <= (drv_d == DRV_IDLE)
                   || (drv_d == DRV_HIGH && trans_d);
        sig_q   <= (drv_d == DRV_LOW)
                   || (drv_d == DRV_HIGH && !trans_d);
        resp_q  <= !frame_ctrl_n[g] && !thermal_limit[g]
                   && bus_return_raw[g];
      end
    end

    always_comb
    begin
      status_w[g] = 32'h0000_0000;
      status_w[g][STS_CENTRE_LSB +: 10] = centre_q;
      status_w[g][STS_CODE_LSB +: 6]    = code_q;
      status_w[g][STS_FAST_BIT]         = (fast_left_q != 7'h00);
      status_w[g][STS_FRAME_BIT]        = !frame_ctrl_n[g];
    end

    assign bus_level_ctrl[g]     = level_q;
    assign bus_drive_state[g]    = drv_q;
    assign idle_drv_en[g]        = idle_q;
    assign signal_drv_en[g]      = sig_q;
    assign slave_response_bit[g] = resp_q;
    assign spread_dac_code[g]    = code_q;
    assign centre_dac_code[g]    = centre_q;
  end

endmodule // bus_phy_spread

// >>> verif/bus_phy_spread_properties.sv
`timescale 1ns/100ps
module bus_phy_spread_properties
  import bus_phy_pkg::*;
#(
  parameter int FAST_CYC = FAST_UPDATE_CYC,
  parameter int SLOW_CYC = SLOW_UPDATE_CYC
)(
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic [NUM_CH-1:0]    frame_ctrl_n,
  input wire logic [NUM_CH-1:0]    tx_bit_take,
  input wire logic [NUM_CH-1:0]    bus_level_ctrl,
  input wire logic [NUM_CH-1:0]    thermal_limit,
  input wire logic [NUM_CH-1:0]    bus_return_raw,
  input wire logic [NUM_CH-1:0]    slave_response_bit,
  input wire drive_state_t [NUM_CH-1:0] bus_drive_state,
  input wire logic [NUM_CH-1:0]    idle_drv_en,
  input wire logic [NUM_CH-1:0]    signal_drv_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Lead bit lasts a whole bit time, far more than four cycles
  sequence lead_bit;
    ##1 bus_level_ctrl[0] [*4];
  endsequence
  sequence bit_opens;
    ##[1:2] !bus_level_ctrl[0];
  endsequence

  a_hot_hiz: assert property (
    thermal_limit[0] |=> bus_drive_state[0] == DRV_HIZ
    && !slave_response_bit[0]) else $error("hot channel not off");
  a_resp_gated: assert property (
    frame_ctrl_n[0] |=> !slave_response_bit[0])
    else $error("response outside frame");
  a_resp_pass: assert property (
    !frame_ctrl_n[0] && !thermal_limit[0] |=>
    slave_response_bit[0] == $past(bus_return_raw[0]))
    else $error("response not passed");
  a_idle_map: assert property (
    frame_ctrl_n[0] && !thermal_limit[0] |=> bus_drive_state[0] ==
    ($past(bus_level_ctrl[0]) ? DRV_IDLE : DRV_HIZ))
    else $error("idle state wrong");
  a_signal_map: assert property (
    !frame_ctrl_n[0] && !thermal_limit[0] |=> bus_drive_state[0] ==
    ($past(bus_level_ctrl[0]) ? DRV_HIGH : DRV_LOW))
    else $error("signal state wrong");
  a_idle_drv: assert property (
    (bus_drive_state[0] == DRV_IDLE) [*2] |->
    idle_drv_en[0] && !signal_drv_en[0]) else $error("idle driver");
  a_hiz_drv: assert property (
    (bus_drive_state[0] == DRV_HIZ) [*2] |->
    !idle_drv_en[0] && !signal_drv_en[0]) else $error("driver on");
  a_sig_drv: assert property (
    bus_drive_state[0] == DRV_LOW
    || ($past(bus_drive_state[0]) == DRV_LOW
        && bus_drive_state[0] == DRV_HIGH) |->
    signal_drv_en[0] && !idle_drv_en[0]) else $error("signal driver");
  a_handoff_drv: assert property (
    $past(bus_drive_state[0]) == DRV_IDLE
    && bus_drive_state[0] == DRV_HIGH |->
    idle_drv_en[0] && !signal_drv_en[0]) else $error("handoff driver");
  a_lead_bit: assert property (
    $fell(frame_ctrl_n[0]) |-> lead_bit) else $error("no lead bit");
  a_bit_opens: assert property (
    tx_bit_take[0] |-> bit_opens) else $error("bit without fall");
endmodule // bus_phy_spread_properties

// >>> verif/slave_node_model.sv
`timescale 1ns/100ps
module slave_node_model (
  input  wire logic sys_clk,
  input  wire logic frame_ctrl_n,
  input  wire logic bus_level_ctrl,
  input  wire logic slow,
  output logic      bus_return_raw
);
  logic       lvl_q = 1'b1;
  logic [2:0] cnt_q = 3'h0;
  initial bus_return_raw = 1'b0;
  // Released line toggles so stale data never passes for an answer
  always @(posedge sys_clk)
  begin
    lvl_q <= bus_level_ctrl;
    if (frame_ctrl_n)
      bus_return_raw <= ~bus_return_raw;
    else if (slow ? bus_level_ctrl & ~lvl_q : ~bus_level_ctrl & lvl_q)
    begin
      cnt_q <= cnt_q + 3'h1;
      bus_return_raw <= cnt_q[0] ^ cnt_q[2];
    end
  end
endmodule // slave_node_model

// >>> verif/tb.sv
`timescale 1ns/100ps
module tb;
  import bus_phy_pkg::*;
  localparam int FAST_CYC = 200;
  localparam int SLOW_CYC = 2000;
  localparam int OSC      = 275;
  logic                      sys_clk;
  logic                      rst;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [11:0]               paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic [NUM_CH-1:0]         frame_ctrl_n;
  logic [NUM_CH-1:0]         tx_bit;
  logic [NUM_CH-1:0]         tx_bit_take;
  logic [NUM_CH-1:0]         bus_level_ctrl;
  logic [NUM_CH-1:0]         thermal_limit;
  logic [NUM_CH-1:0]         bus_return_raw;
  logic [NUM_CH-1:0]         slave_response_bit;
  drive_state_t [NUM_CH-1:0] bus_drive_state;
  logic [NUM_CH-1:0]         idle_drv_en;
  logic [NUM_CH-1:0]         signal_drv_en;
  logic [NUM_CH-1:0][5:0]    spread_dac_code;
  logic [NUM_CH-1:0][9:0]    centre_dac_code;
  logic [NUM_CH-1:0][5:0]    code_q [4];
  logic [31:0]               rd;
  logic                      err;
  logic                      slow;
  logic                      moved;
  int                        n_mismatch;
  int                        checks_done;
  int                        now;

  bus_phy_spread #(
    .FAST_CYC(FAST_CYC),
    .SLOW_CYC(SLOW_CYC)
  ) dut_u (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frame_ctrl_n, .tx_bit, .tx_bit_take,
    .bus_level_ctrl, .thermal_limit, .bus_return_raw,
    .slave_response_bit, .bus_drive_state, .idle_drv_en, .signal_drv_en,
    .spread_dac_code, .centre_dac_code
  );

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_node
    slave_node_model node_u (
      .sys_clk(sys_clk),
      .frame_ctrl_n(frame_ctrl_n[c]),
      .bus_level_ctrl(bus_level_ctrl[c]),
      .slow(slow),
      .bus_return_raw(bus_return_raw[c])
    );
  end

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) now <= now + 1;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wait_take();
    int t;
    t = 0;
    do
    begin
      @(posedge sys_clk);
      t++;
    end
    while (tx_bit_take[0] !== 1'b1 && t < 4000);
    check("take", tx_bit_take[0], 1'b1);
  endtask

  // Four bits, 1 0 1 0, so the frame length stays paired
  task automatic run_frame(input bit timed);
    int tk;
    int prev;
    int k;
    int lo;
    moved = 1'b0;
    frame_ctrl_n <= 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      tx_bit <= {NUM_CH{~i[0]}};
      prev = tk;
      wait_take();
      tk = now;
      if (timed && i > 0)
        check("period", tk - prev, 3 * OSC);
      k = 0;
      lo = 0;
      while ((k < 3 || bus_level_ctrl[0] !== 1'b1) && k < 4000)
      begin
        @(posedge sys_clk);
        k++;
        if (k == 3)
          code_q[i] = spread_dac_code;
        if (k > 3 && spread_dac_code !== code_q[i])
          moved = 1'b1;
        if (bus_level_ctrl[0] === 1'b0)
          lo++;
      end
      if (timed)
        check("low", lo, i[0] ? 2 * OSC : OSC);
    end
    // End inside the last bit's high third so no fifth bit is taken
    repeat (OSC / 2) @(posedge sys_clk);
    frame_ctrl_n <= 2'h3;
    repeat (20) @(posedge sys_clk);
    check("moved", moved, 1'b0);
  endtask

  task automatic s_reset();
    check("drive", bus_drive_state, {NUM_CH{DRV_IDLE}});
    apb(1'b0, REG_STATUS, 32'h0);
    check("status", rd, {14'h0, 2'h1, SPREAD_MID, CENTRE_RST});
    apb(1'b0, CH_STRIDE + REG_SS_CTRL, 32'h0);
    check("ctrl", rd, 32'(SSC_RST));
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped", err, 1'b1);
  endtask

  task automatic s_thermal();
    thermal_limit <= 2'h3;
    repeat (3) @(posedge sys_clk);
    check("hot", bus_drive_state, {NUM_CH{DRV_HIZ}});
    check("hot en", {idle_drv_en, signal_drv_en}, 4'h0);
    frame_ctrl_n <= 2'h0;
    repeat (3) @(posedge sys_clk);
    check("hot resp", slave_response_bit, 2'h0);
    check("hot frame", bus_drive_state, {NUM_CH{DRV_HIZ}});
    thermal_limit <= 2'h0;
    repeat (3) @(posedge sys_clk);
    check("lead", bus_drive_state, {NUM_CH{DRV_HIGH}});
    frame_ctrl_n <= 2'h3;
    repeat (5) @(posedge sys_clk);
    check("idle", bus_drive_state, {NUM_CH{DRV_IDLE}});
    repeat (20) @(posedge sys_clk);
  endtask

  // Channel 1 is either switched off or has no deviation
  task automatic s_spread();
    for (int n = 0; n < 4; n++)
    begin
      slow <= n[0];
      apb(1'b1, REG_SS_CTRL, 32'h7 | (32'(n) << SSC_LEN_LSB));
      apb(1'b1, CH_STRIDE + REG_SS_CTRL, n[0] ? 32'h1 : 32'h6);
      run_frame(1'b0);
      for (int i = 0; i < 4; i += 2)
        check("pair", code_q[i + 1][0], 6'h3f - code_q[i][0]);
      check("ch1", code_q[1][1], SPREAD_MID);
    end
  endtask

  task automatic s_fast();
    apb(1'b0, REG_STATUS, 32'h0);
    check("slow", rd[STS_FAST_BIT], 1'b0);
    apb(1'b1, REG_OFFSET, 32'h40);
    apb(1'b0, REG_STATUS, 32'h0);
    check("fast", rd[STS_FAST_BIT], 1'b1);
    repeat ((FAST_UPDATES - 4) * FAST_CYC) @(posedge sys_clk);
    apb(1'b0, REG_STATUS, 32'h0);
    check("fast end", rd[STS_FAST_BIT], 1'b1);
    repeat (6 * FAST_CYC) @(posedge sys_clk);
    apb(1'b0, REG_STATUS, 32'h0);
    check("fast over", rd[STS_FAST_BIT], 1'b0);
    check("centre", centre_dac_code[0] < CENTRE_RST, 1'b1);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, slow} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    frame_ctrl_n = 2'h3;
    tx_bit = 2'h3;
    thermal_limit = 2'h0;
    n_mismatch = 0;
    checks_done = 0;
    now = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    s_reset();
    s_thermal();
    run_frame(1'b1);
    check("centre", centre_dac_code[0], CENTRE_RST);
    check("mid", code_q[3], {NUM_CH{SPREAD_MID}});
    s_spread();
    s_fast();
    end_sim();
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end
endmodule // tb

bind bus_phy_spread bus_phy_spread_properties #(
  .FAST_CYC(FAST_CYC),
  .SLOW_CYC(SLOW_CYC)
) chk_u (
  .sys_clk, .rst, .frame_ctrl_n, .tx_bit_take, .bus_level_ctrl,
  .thermal_limit, .bus_return_raw, .slave_response_bit,
  .bus_drive_state, .idle_drv_en, .signal_drv_en
);
